//--- src/ssu_baud_gen.sv
`timescale 1ns/1ps
// Half-period tick generator for the master shift clock.
module ssu_baud_gen (
  input  logic        sys_clk,
  input  logic        reset_n,
  input  logic        run,
  input  logic [15:0] reload,
  output logic        tick
);

  // Down counter; one tick every reload plus one clocks.
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // The counter is preset while stopped so the first half period is whole.
  assign tick  = run & (cnt_q == 16'h0000);
  assign cnt_d = (~run | tick) ? reload : cnt_q - 16'h0001;

  // Counter register.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= ssu_pkg::BAUD_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- src/ssu_pkg.sv
package ssu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB port.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_BAUD  = 8'h04;
  localparam logic [7:0] OFS_TXD   = 8'h08;
  localparam logic [7:0] OFS_RXD   = 8'h0C;
  localparam logic [7:0] OFS_STS   = 8'h10;
  localparam logic [7:0] OFS_MASK  = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions.
  localparam int CTL_EN  = 0;  // Block enable.
  localparam int CTL_MST = 1;  // Master role when set.
  localparam int CTL_HDX = 2;  // Half duplex when set.
  localparam int CTL_MSB = 3;  // Most significant bit first when set.
  localparam int CTL_POL = 4;  // Idle level of the shift clock.
  localparam int CTL_PHA = 5;  // Shift on leading edge when set.
  localparam int CTL_WID = 8;  // Three bits: data bits minus one.

  // Status and mask bit positions.
  localparam int ST_TXE  = 0;  // Transmit buffer emptied.
  localparam int ST_RXF  = 1;  // Receive buffer filled.
  localparam int ST_RERR = 2;  // Receive overrun.
  localparam int ST_PERR = 3;  // Select dropped inside a frame.
  localparam int ST_BERR = 4;  // Slave clock edges too close.
  localparam int ST_TERR = 5;  // Transmit underrun or overwrite.

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [8:0]  CFG_RST  = 9'h1C0;
  localparam logic [15:0] BAUD_RST = 16'h0003;
  localparam logic [5:0]  MASK_RST = 6'h00;
  localparam logic [3:0]  SYNC_RST = 4'h8;

  // Fewest system clocks accepted between two slave clock edges.
  localparam logic [3:0]  SLV_MIN_GAP = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } ssu_state_t;

  // Configuration carried as one word.
  typedef struct packed {
    logic [2:0] wid_m1;
    logic       pha;
    logic       pol;
    logic       msb;
    logic       hdx;
    logic       mst;
    logic       en;
  } ssu_cfg_t;

  // Event and status bits, bit 5 first.
  typedef struct packed {
    logic terr;
    logic berr;
    logic perr;
    logic rerr;
    logic rxf;
    logic txe;
  } ssu_evt_t;

endpackage

//--- src/ssu_sync_serial.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Contract
// - Master clock comes from 16-bit baud generator.
// - Slave shifts on the external master's clock.
// - Full duplex and half duplex both supported.
// - Frame width programmable, two to eight bits.
// - Shift order selectable, LSB or MSB first.
// - Shift clock idle level selectable.
// - Data shifts on leading or trailing edge.
// - Transmit and receive paths double buffered.
// - Interrupt when transmit buffer becomes empty.
// - Interrupt when receive buffer becomes full.
// - Error interrupt on four detected faults.
// - Data lines routed to pins by role.
// - Clock driven as master, taken as slave.
module ssu_sync_serial (
  input  logic        sys_clk,
  input  logic        reset_n,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        irq,
  input  logic        shift_clk_pin_i,
  output logic        master_shift_clock_out,
  output logic        shift_clk_pin_oe,
  input  logic        master_out_slave_in_pin_i,
  output logic        master_out_slave_in_pin_o,
  output logic        master_out_slave_in_pin_oe,
  input  logic        master_in_slave_out_pin_i,
  output logic        master_in_slave_out_pin_o,
  output logic        master_in_slave_out_pin_oe,
  input  logic        slave_select_n_i
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A width field of zero is taken as two bits.
  function automatic logic [2:0] eff_wm1(input logic [2:0] f);
    return (f == 3'h0) ? 3'h1 : f;
  endfunction

  // Moves a word between the low bits and the top of the byte.
  function automatic logic [7:0] align(input logic [7:0] d, input logic [2:0] m,
                                       input logic left);
    logic [2:0] sh;
    sh = 3'h7 - m;
    return left ? (d << sh) : (d >> sh);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  ssu_pkg::ssu_cfg_t   cfg_q;      // Control register.
  logic [15:0]         baud_q;     // Baud reload value.
  logic [5:0]          msk_q;      // Interrupt mask.
  ssu_pkg::ssu_evt_t   sts_q;      // Sticky status.
  ssu_pkg::ssu_evt_t   sts_d;      // Next status.
  ssu_pkg::ssu_evt_t   evt;        // Events of this cycle.
  ssu_pkg::ssu_state_t state_q;    // Frame engine state.
  ssu_pkg::ssu_state_t state_d;    // Next engine state.
  logic [7:0]          txbuf_q;    // Transmit buffer.
  logic                tx_full_q;  // Transmit buffer holds a word.
  logic [7:0]          rxbuf_q;    // Receive buffer.
  logic                rx_full_q;  // Receive buffer holds a word.
  logic [7:0]          tx_sh_q;    // Transmit shift register.
  logic [7:0]          rx_sh_q;    // Receive shift register.
  logic [3:0]          hcnt_q;     // Clock edges seen in the frame.
  logic                sclk_q;     // Master shift clock level.
  logic                drive_q;    // Data pin driven this frame.
  logic [3:0]          gap_q;      // Clocks since last slave edge.
  logic [3:0]          sy1_q;      // Pin synchroniser, first stage.
  logic [3:0]          sy2_q;      // Pin synchroniser, second stage.
  logic                s_prev_q;   // Slave clock one cycle back.
  logic [31:0]         prdata_q;   // Read data held for the access.

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes without wait states.
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire h_ctl  = paddr == ssu_pkg::OFS_CTRL;
  wire h_bd   = paddr == ssu_pkg::OFS_BAUD;
  wire h_tx   = paddr == ssu_pkg::OFS_TXD;
  wire h_rx   = paddr == ssu_pkg::OFS_RXD;
  wire h_st   = paddr == ssu_pkg::OFS_STS;
  wire h_mk   = paddr == ssu_pkg::OFS_MASK;
  wire h_sta  = paddr == ssu_pkg::OFS_STATE;
  wire h_any  = h_ctl | h_bd | h_tx | h_rx | h_st | h_mk | h_sta;

  // Unmapped addresses answer with an error and read as zero.
  assign pready  = 1'b1;
  assign pslverr = acc & ~h_any;
  assign prdata  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins: 0 clock, 1 out pin, 2 in pin, 3 select.
  wire s_clk = sy2_q[0];
  wire sel_n = sy2_q[3];

  // Pins come from another domain, so two flops before any use.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_q    <= ssu_pkg::SYNC_RST;
      sy2_q    <= ssu_pkg::SYNC_RST;
      s_prev_q <= 1'b0;
    end else begin
      sy1_q    <= {slave_select_n_i, master_in_slave_out_pin_i,
                   master_out_slave_in_pin_i, shift_clk_pin_i};
      sy2_q    <= sy1_q;
      s_prev_q <= s_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock edges of the running frame.
  wire       busy = state_q == ssu_pkg::ST_SHIFT;
  wire [2:0] wm1  = eff_wm1(cfg_q.wid_m1);
  wire       tick;

  // Master half periods; the generator only runs during a frame.
  ssu_baud_gen u_baud (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .run     (busy & cfg_q.mst),
    .reload  (baud_q),
    .tick    (tick)
  );

  // Slave frames follow the received clock instead of the generator.
  wire s_edge = s_clk ^ s_prev_q;
  wire lead   = cfg_q.mst ? (sclk_q == cfg_q.pol)
                          : (s_prev_q == cfg_q.pol);
  wire edge_e = busy & (cfg_q.mst ? tick : s_edge);

  // Sample on one edge of the pair, change the output on the other.
  wire smp_e  = edge_e & (lead ^ cfg_q.pha);
  wire shf_e  = edge_e & ~(lead ^ cfg_q.pha)
              & ~(cfg_q.pha & (hcnt_q == 4'h0));

  // The frame ends on its last clock edge, two per bit.
  wire done   = edge_e & (hcnt_q == {wm1, 1'b1});

  ////////////////////////////////////////////////////////////////////////////
  // Frame start and abort conditions.
  wire m_start = ~busy & cfg_q.en & cfg_q.mst & tx_full_q;
  wire s_start = ~busy & cfg_q.en & ~cfg_q.mst & ~sel_n;
  wire start   = m_start | s_start;
  wire tx_take = start & tx_full_q;
  wire abort   = busy & ~cfg_q.mst & sel_n;
  wire b_err   = busy & ~cfg_q.mst & s_edge
               & (gap_q < ssu_pkg::SLV_MIN_GAP);

  ////////////////////////////////////////////////////////////////////////////
  // Data paths. In half duplex both ends share one data wire.
  wire rxd = (cfg_q.hdx ^ cfg_q.mst) ? sy2_q[2] : sy2_q[1];
  wire [7:0] rx_sh_s = cfg_q.msb ? {rx_sh_q[6:0], rxd}
                                 : {rxd, rx_sh_q[7:1]};
  wire [7:0] rx_nx   = smp_e ? rx_sh_s : rx_sh_q;
  wire [7:0] tx_sh_s = cfg_q.msb ? {tx_sh_q[6:0], 1'b0}
                                 : {1'b0, tx_sh_q[7:1]};
  wire [7:0] tx_load = ~tx_full_q ? 8'h00 : cfg_q.msb ? align(txbuf_q, wm1, 1'b1) : txbuf_q;
  wire       ob      = cfg_q.msb ? tx_sh_q[7] : tx_sh_q[0];

  // Buffer access from the bus.
  wire tx_wr = wr & h_tx;
  wire rx_rd = rd & h_rx;
  wire tx_ok = ~tx_full_q | tx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. Master drives clock and out pin, slave the in pin.
  assign master_shift_clock_out     = sclk_q;
  assign shift_clk_pin_oe           = cfg_q.en & cfg_q.mst;
  assign master_out_slave_in_pin_o  = ob;
  assign master_out_slave_in_pin_oe = cfg_q.en & cfg_q.mst
                                    & (~cfg_q.hdx | busy);
  assign master_in_slave_out_pin_o  = ob;
  assign master_in_slave_out_pin_oe = cfg_q.en & ~cfg_q.mst & busy
                                    & drive_q & ~sel_n;

  ////////////////////////////////////////////////////////////////////////////
  // Events feeding the sticky status.
  assign evt.txe  = tx_take;
  assign evt.rxf  = done;
  assign evt.rerr = done & rx_full_q & ~rx_rd;
  assign evt.perr = abort;
  assign evt.berr = b_err;
  assign evt.terr = (s_start & ~tx_full_q & ~cfg_q.hdx)
                  | (tx_wr & ~tx_ok);

  // Writing one clears a bit; a new event wins over the clear.
  wire [5:0] w1c = (wr & h_st) ? pwdata[5:0] : 6'h00;
  assign sts_d = (sts_q & ~w1c) | evt;
  assign irq   = |(sts_q & msk_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer, sampled in the setup phase.
  wire [4:0]  sta = {sel_n, cfg_q.mst ? sclk_q : s_clk, rx_full_q, tx_full_q, busy};
  wire [31:0] rdv = h_ctl ? {21'h000000, cfg_q.wid_m1, 2'b00, cfg_q[5:0]}
                  : h_bd  ? {16'h0000, baud_q}
                  : h_tx  ? {24'h000000, txbuf_q}
                  : h_rx  ? {24'h000000, rxbuf_q}
                  : h_st  ? {26'h0000000, sts_q}
                  : h_mk  ? {26'h0000000, msk_q}
                  : h_sta ? {27'h0000000, sta}
                  : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Engine state: a frame ends at its last edge, on abort or on disable.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ssu_pkg::ST_IDLE: begin
        if (start) begin
          state_d = ssu_pkg::ST_SHIFT;
        end
      end
      ssu_pkg::ST_SHIFT: begin
        if (done | abort | ~cfg_q.en) begin
          state_d = ssu_pkg::ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q    <= ssu_pkg::CFG_RST;
      baud_q   <= ssu_pkg::BAUD_RST;
      msk_q    <= ssu_pkg::MASK_RST;
      sts_q    <= '0;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr & h_ctl) begin
        cfg_q <= ssu_pkg::ssu_cfg_t'({pwdata[ssu_pkg::CTL_WID +: 3], pwdata[5:0]});
      end
      if (wr & h_bd) begin
        baud_q <= pwdata[15:0];
      end
      if (wr & h_mk) begin
        msk_q <= pwdata[5:0];
      end
      sts_q <= sts_d;
      if (psel & ~penable) begin
        prdata_q <= rdv;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers: a word waits here while the shifter is busy.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txbuf_q   <= 8'h00;
      tx_full_q <= 1'b0;
      rxbuf_q   <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      // A write while full is dropped and flagged.
      if (tx_wr & tx_ok) begin
        txbuf_q <= pwdata[7:0];
      end
      tx_full_q <= (tx_wr & tx_ok) | (tx_full_q & ~tx_take);
      // A finished word overwrites an unread one.
      if (done) begin
        rxbuf_q <= cfg_q.msb ? rx_nx : align(rx_nx, wm1, 1'b0);
      end
      rx_full_q <= done | (rx_full_q & ~rx_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter, edge count and clock level.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ssu_pkg::ST_IDLE;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      hcnt_q  <= 4'h0;
      sclk_q  <= 1'b0;
      drive_q <= 1'b0;
      gap_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      // The first bit sits on the line before the first edge.
      if (start) begin
        tx_sh_q <= tx_load;
        drive_q <= tx_full_q | ~cfg_q.hdx;
      end else if (shf_e) begin
        tx_sh_q <= tx_sh_s;
      end
      rx_sh_q <= start ? 8'h00 : rx_nx;
      hcnt_q  <= start ? 4'h0 : hcnt_q + {3'h0, edge_e};
      // Toggles on each tick, holds between ticks in a frame, rests at the idle level outside a frame.
      sclk_q  <= (busy & cfg_q.mst & tick) ? ~sclk_q
               : busy ? sclk_q : cfg_q.pol;
      // Measures slave half periods for the rate check.
      if (s_edge) begin
        gap_q <= 4'h0;
      end else if (gap_q != 4'hF) begin
        gap_q <= gap_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers: samples per frame and master half period.
  logic [3:0]  smp_q;
  logic [15:0] hp_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_q <= 4'h0;
      hp_q  <= 16'h0000;
    end else begin
      smp_q <= start ? 4'h0 : smp_q + {3'h0, smp_e};
      hp_q  <= (start | tick) ? 16'h0000 : hp_q + 16'h0001;
    end
  end

  // Idle clock rests at the chosen level.
  a_clk_idle_level: assert property (
    (!busy && $past(!busy) && $stable(cfg_q.pol)) |-> (sclk_q == cfg_q.pol))
    else $error("shift clock not at idle level");

  // Master half period equals reload plus one.
  a_baud_half_period: assert property (
    (busy && cfg_q.mst && tick && $stable(baud_q)) |-> (hp_q == baud_q))
    else $error("master half period wrong");

  // Every completed frame samples exactly the programmed bit count.
  a_frame_bit_count: assert property (
    done |-> ((smp_q + {3'h0, smp_e}) == ({1'b0, wm1} + 4'h1)))
    else $error("frame bit count wrong");

  // A finished frame fills the receive buffer and flags it.
  a_rx_full_flag: assert property (
    done |=> (rx_full_q && sts_q.rxf && !busy))
    else $error("receive full not raised");

  // Taking the transmit word empties the buffer and flags it.
  a_tx_empty_flag: assert property (
    (tx_take && !tx_wr) |=> (!tx_full_q && sts_q.txe && busy))
    else $error("transmit empty not raised");

  // An unread word overwritten raises the receive error.
  a_rx_overrun: assert property (
    (done && rx_full_q && !rx_rd) |=> sts_q.rerr)
    else $error("overrun not flagged");

  // A slave never drives the clock pin nor runs the generator.
  a_slave_ext_clock: assert property (
    !cfg_q.mst |-> (!shift_clk_pin_oe && !tick))
    else $error("slave drove shift clock");

  // A master in a frame drives out and never the in pin.
  a_master_routing: assert property (
    (cfg_q.mst && busy) |-> (master_out_slave_in_pin_oe && !master_in_slave_out_pin_oe))
    else $error("master data routing wrong");

endmodule

//--- testbench/ssu_spi_peer.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Serial slave that stands opposite the block when the block is master.
module ssu_spi_peer (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       msb,
  input  wire logic [2:0] wid_m1,
  input  wire logic       arm,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      rx_word
);
  int sent;  // Bits presented so far in this frame.
  int got;   // Bits sampled so far in this frame.

  // Bit position of the n-th bit on the wire.
  function automatic int pos(input int n);
    return msb ? (int'(wid_m1) - n) : n;
  endfunction

  initial miso = 1'b1;

  // Arming restarts the frame; with phase 0 the first bit must stand at once.
  always @(posedge arm) begin
    sent = 0;
    got = 0;
    rx_word = 8'h00;
    if (!pha) begin
      miso = reply[pos(0)];
      sent = 1;
    end
  end

  // A leading edge leaves the idle level; phase picks the sampling edge.
  always @(sclk) begin
    if ((sclk != pol) ^ pha) begin
      if (got <= int'(wid_m1)) rx_word[pos(got)] = mosi;
      got++;
    end else if (sent <= int'(wid_m1)) begin
      miso = reply[pos(sent)];
      sent++;
    end else begin
      miso = ~miso;  // Released line shows no stale value.
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: APB master, serial peer and pin resolution.
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, err;
  logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, peer_miso;
  logic        ssn = 1'b1, tb_sclk = 1'b0, arm = 1'b0;
  logic        p_pol = 1'b0, p_pha = 1'b0, p_msb = 1'b0;
  logic [2:0]  p_wid = 3'h7;
  logic [7:0]  reply = 8'h00, peer_rx;
  wire         sclk = sclk_oe ? sclk_o : tb_sclk;
  wire         mosi = mosi_oe ? mosi_o : ~mosi_o;
  wire         miso = miso_oe ? miso_o : peer_miso;
  int          error_cnt = 0, tests_run = 0, edges = 0;
  longint      t_first, t_last;

  ssu_sync_serial ssu_sync_serial_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .shift_clk_pin_i(sclk),
    .master_shift_clock_out(sclk_o), .shift_clk_pin_oe(sclk_oe),
    .master_out_slave_in_pin_i(mosi), .master_out_slave_in_pin_o(mosi_o),
    .master_out_slave_in_pin_oe(mosi_oe), .master_in_slave_out_pin_i(miso),
    .master_in_slave_out_pin_o(miso_o), .master_in_slave_out_pin_oe(miso_oe),
    .slave_select_n_i(ssn));
  ssu_spi_peer ssu_spi_peer_i (.sclk(sclk), .mosi(mosi), .pol(p_pol), .pha(p_pha),
    .msb(p_msb), .wid_m1(p_wid), .arm(arm), .reply(reply), .miso(peer_miso),
    .rx_word(peer_rx));

  initial forever #4 sys_clk = ~sys_clk;

  // Counts shift clock edges and stamps the first and last of them.
  always @(sclk) if (reset_n) begin
    edges++;
    t_last = $time;
    if (edges == 1) t_first = $time;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares and counts; reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      final_report();
    end
    #1;
  endtask

  // Polls a register until the masked bits show the wanted value.
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 300);
    if (n == 300) begin
      error_cnt++;
      final_report();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Master frame in one mode; peer replies with rx while block sends tx.
  task automatic run_frame(input int w, input bit pol, pha, msb, hdx, input int baud,
                           input logic [7:0] tx, rx);
    logic [7:0] m;
    m = 8'hFF >> (8 - w);
    p_pol <= pol;
    p_pha <= pha;
    p_msb <= msb;
    p_wid <= 3'(w - 1);
    apb(1'b1, ssu_pkg::OFS_BAUD, 32'(baud));
    apb(1'b1, ssu_pkg::OFS_CTRL, {21'h0, 3'(w - 1), 2'b00, pha, pol, msb, hdx, 2'b11});
    // Let a new idle level settle on the clock pin before the peer is armed.
    repeat (2) @(posedge sys_clk);
    reply <= rx;
    arm <= 1'b1;
    @(posedge sys_clk);
    arm <= 1'b0;
    #1;
    chk("clock enable", sclk_oe, 1'b1);
    chk("idle clock", sclk, pol);
    edges = 0;
    apb(1'b1, ssu_pkg::OFS_TXD, {24'h0, tx});
    wait_reg(ssu_pkg::OFS_STATE, 32'h4, 32'h4);
    chk("clock edges", 32'(edges), 32'(2 * w));
    chk("frame span", 32'(t_last - t_first), 32'((2 * w - 1) * (baud + 1) * 8));
    chk("clock at rest", sclk, pol);
    apb(1'b0, ssu_pkg::OFS_RXD, 32'h0);
    chk("received word", rd, {24'h0, (hdx ? tx : rx) & m});
    chk("peer word", {24'h0, peer_rx}, {24'h0, tx & m});
    apb(1'b0, ssu_pkg::OFS_STS, 32'h0);
    chk("status", rd, 32'h3);
  endtask

  task t_reset;
    apb(1'b0, ssu_pkg::OFS_CTRL, 32'h0);
    chk("control reset", rd, 32'h700);
    apb(1'b0, ssu_pkg::OFS_BAUD, 32'h0);
    chk("baud reset", rd, 32'h3);
    apb(1'b0, ssu_pkg::OFS_STS, 32'h0);
    chk("status reset", rd, 32'h0);
    chk("irq reset", irq, 1'b0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk("unmapped error", err, 1'b1);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask

  // Every polarity, phase and order, widths two to eight, three baud values.
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      run_frame((i == 7) ? 8 : i + 2, i[0], i[1], i[2], 1'b0, i % 3 + 2,
                8'hA5 ^ 8'(i * 17), 8'h3C + 8'(i));
      apb(1'b1, ssu_pkg::OFS_STS, 32'h3F);
    end
    $display("test modes done");
  endtask

  // Half-duplex master frame reads back its own data line, then the mask.
  task t_irq;
    run_frame(8, 1'b0, 1'b0, 1'b1, 1'b1, 2, 8'h81, 8'h7E);
    apb(1'b1, ssu_pkg::OFS_MASK, 32'h2);
    chk("irq rx full", irq, 1'b1);
    apb(1'b1, ssu_pkg::OFS_MASK, 32'h0);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, ssu_pkg::OFS_MASK, 32'h1);
    chk("irq tx empty", irq, 1'b1);
    apb(1'b1, ssu_pkg::OFS_STS, 32'h1);
    chk("irq cleared", irq, 1'b0);
    apb(1'b1, ssu_pkg::OFS_STS, 32'h3F);
    apb(1'b1, ssu_pkg::OFS_MASK, 32'h0);
    $display("test irq done");
  endtask

  // Second word buffered behind a busy shifter; a third is refused.
  task t_dbuf;
    apb(1'b1, ssu_pkg::OFS_CTRL, 32'h703);
    edges = 0;
    apb(1'b1, ssu_pkg::OFS_TXD, 32'h11);
    apb(1'b1, ssu_pkg::OFS_TXD, 32'h22);
    apb(1'b1, ssu_pkg::OFS_TXD, 32'h33);
    apb(1'b0, ssu_pkg::OFS_STS, 32'h0);
    chk("tx overwrite", rd & 32'h20, 32'h20);
    wait_reg(ssu_pkg::OFS_STS, 32'h4, 32'h4);
    chk("two frames", 32'(edges), 32'd32);
    apb(1'b1, ssu_pkg::OFS_STS, 32'h3F);
    $display("test buffering done");
  endtask

  // Select lifted inside a slave frame is a phase fault.
  task t_slave;
    apb(1'b1, ssu_pkg::OFS_CTRL, 32'h701);
    chk("slave clock enable", sclk_oe, 1'b0);
    @(posedge sys_clk);
    ssn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("slave drives data", miso_oe, 1'b1);
    @(posedge sys_clk);
    ssn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, ssu_pkg::OFS_STS, 32'h0);
    chk("phase fault", rd & 32'h8, 32'h8);
    chk("slave underrun", rd & 32'h20, 32'h20);
    $display("test slave done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_dbuf();
    t_slave();
    final_report();
  end
endmodule
